// ### ccx_core.sv
// Carry toggle, zero fill, invert and flag-only subtract unit with APB
`timescale 1ns/1ps
// Contract
// - The carry toggle operation inverts the carry flag.
// - Carry toggle leaves zero, sign, overflow, D and H flags alone.
// - Zero fill writes zero into the destination byte.
// - Zero fill leaves every flag exactly as it was.
// - Indirect zero fill clears the pointed-to byte, not the pointer.
// - Invert replaces the destination byte with its bitwise inverse.
// - Indirect invert inverts the pointed-to byte, not the pointer.
// - Flag-only subtract writes neither destination nor source.
// - Flag-only subtract sets carry on borrow, clears it otherwise.
// - Flag-only subtract sets Z and S from the difference, keeps D, H.
// - Flag-only subtract sets V on signed overflow, clears it otherwise.
module ccx_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_READ, ST_EXEC, ST_WRITE
  } ccx_state_t;

  ccx_state_t       state;
  ccx_state_t       next_state;
  ccx_pkg::ccx_op_t op;
  logic [7:0]       rf [ccx_pkg::RF_DEPTH];
  logic [7:0]       dst_addr;
  logic [7:0]       src_addr;
  logic [7:0]       eff_dst;
  logic [7:0]       flags;
  logic [7:0]       rf_addr;
  logic [7:0]       dst_val;
  logic [7:0]       src_val;
  logic             indirect;
  logic             done;
  logic             illegal;
  logic             captured;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic sel_cmd;
  logic sel_oper;
  logic sel_flags;
  logic sel_status;
  logic sel_rf_addr;
  logic sel_rf_data;
  logic hit;

  ccx_apb_dec u_dec (
    .paddr       (paddr),
    .sel_cmd     (sel_cmd),
    .sel_oper    (sel_oper),
    .sel_flags   (sel_flags),
    .sel_status  (sel_status),
    .sel_rf_addr (sel_rf_addr),
    .sel_rf_data (sel_rf_data),
    .hit         (hit)
  );

  wire        busy     = (state != ST_IDLE);
  // Capture also when a setup cycle was missed while frozen, so no hang
  wire        setup    = psel & ~captured & ce;
  wire        access   = psel & penable & pready;
  wire        wr_acc   = access & pwrite & hit;
  wire [7:0]  wbyte    = pwdata[7:0];
  wire        cmd_wr   = wr_acc & sel_cmd & ~busy;
  wire        done_clr = wr_acc & sel_status & pwdata[ccx_pkg::ST_DONE];
  wire        ill_clr  = wr_acc & sel_status & pwdata[ccx_pkg::ST_ILLEGAL];

  // Opcode decode; anything else written while idle is flagged, and it is never executed
  wire op_tog  = (wbyte == ccx_pkg::OPC_CARRY_TOGGLE);
  wire op_zf   = (wbyte == ccx_pkg::OPC_ZERO_FILL);
  wire op_zfi  = (wbyte == ccx_pkg::OPC_ZERO_FILL_IR);
  wire op_inv  = (wbyte == ccx_pkg::OPC_INVERT);
  wire op_invi = (wbyte == ccx_pkg::OPC_INVERT_IR);
  wire op_sub  = (wbyte == ccx_pkg::OPC_FLAG_SUB);
  wire op_ok   = op_tog | op_zf | op_zfi | op_inv | op_invi | op_sub;
  wire start   = cmd_wr & op_ok;

  ccx_pkg::ccx_op_t dec_op;
  assign dec_op = op_tog              ? ccx_pkg::OP_CARRY_TOGGLE :
                  (op_zf | op_zfi)    ? ccx_pkg::OP_ZERO_FILL :
                  (op_inv | op_invi)  ? ccx_pkg::OP_INVERT :
                  op_sub              ? ccx_pkg::OP_FLAG_SUB :
                                        ccx_pkg::OP_NONE;

  wire [31:0] status_word = {29'h0000_0000, illegal, done, busy};
  wire [31:0] oper_word   = {16'h0000, src_addr, dst_addr};
  wire [31:0] rd_mux =
    sel_oper    ? oper_word :
    sel_flags   ? {24'h00_0000, flags} :
    sel_status  ? status_word :
    sel_rf_addr ? {24'h00_0000, rf_addr} :
    sel_rf_data ? {24'h00_0000, rf[rf_addr]} :
                  32'h0000_0000;

  // Answer one cycle after read data has been captured
  assign pready  = penable & ce & captured;
  assign pslverr = psel & penable & ~hit;

  // ----------------------------------------------------------------
  // Execution datapath
  // ----------------------------------------------------------------
  logic [7:0] alu_result;
  logic       alu_wr;
  logic [7:0] alu_flags;

  ccx_alu u_alu (
    .op        (op),
    .dst       (dst_val),
    .src       (src_val),
    .flags_in  (flags),
    .result    (alu_result),
    .wr_en     (alu_wr),
    .flags_out (alu_flags)
  );

  // Every opcode spends the same four busy cycles
  always_comb begin
    case (state)
      ST_IDLE:  next_state = start ? ST_ADDR : ST_IDLE;
      ST_ADDR:  next_state = ST_READ;
      ST_READ:  next_state = ST_EXEC;
      ST_EXEC:  next_state = ST_WRITE;
      ST_WRITE: next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  wire wb      = ce & (state == ST_WRITE);
  wire rf_wb   = wb & alu_wr;
  wire rf_bus  = wr_acc & sel_rf_data & ~busy;
  wire fl_bus  = wr_acc & sel_flags & ~busy;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      op       <= ccx_pkg::OP_NONE;
      indirect <= 1'b0;
      dst_addr <= 8'h00;
      src_addr <= 8'h00;
      rf_addr  <= 8'h00;
      eff_dst  <= 8'h00;
      dst_val  <= 8'h00;
      src_val  <= 8'h00;
    end else if (ce) begin
      state <= next_state;
      if (start) begin
        op       <= dec_op;
        indirect <= op_zfi | op_invi;
      end
      if (wr_acc & sel_oper & ~busy) begin
        dst_addr <= pwdata[ccx_pkg::OPER_DST_LSB +: 8];
        src_addr <= pwdata[ccx_pkg::OPER_SRC_LSB +: 8];
      end
      if (wr_acc & sel_rf_addr) begin
        rf_addr <= wbyte;
      end
      if (state == ST_ADDR) begin
        // Pointer only read, never written back
        eff_dst <= indirect ? rf[dst_addr] : dst_addr;
      end
      if (state == ST_READ) begin
        dst_val <= rf[eff_dst];
        src_val <= rf[src_addr];
      end
    end
  end

  // Set beats clear so a finishing operation is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done    <= 1'b0;
      illegal <= 1'b0;
    end else if (ce) begin
      done    <= wb | (done & ~done_clr);
      illegal <= (cmd_wr & ~op_ok) | (illegal & ~ill_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= ccx_pkg::FLAGS_RESET;
    end else if (ce) begin
      if (wb) begin
        flags <= alu_flags;
      end else if (fl_bus) begin
        flags <= wbyte & ccx_pkg::FLAGS_MASK;
      end
    end
  end

  // Only one write port: execution owns it while busy
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (rf_wb) begin
        rf[eff_dst] <= alu_result;
      end else if (rf_bus) begin
        rf[rf_addr] <= wbyte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata   <= 32'h0000_0000;
      captured <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        prdata   <= pwrite ? 32'h0000_0000 : rd_mux;
        captured <= 1'b1;
      end else if (access) begin
        captured <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wb(ccx_pkg::ccx_op_t o);
    wb && op == o;
  endsequence

  sequence s_run;
    (busy && ce)[*4] ##1 !busy;
  endsequence

  a_start_run_len: assert property (@(posedge pclk) disable iff (!presetn)
    (start && ce) ##1 ce[*4] |=> $past(busy) && !busy && done)
    else $error("operation did not finish in four cycles");

  a_ccf_carry_flip: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_CARRY_TOGGLE) |=>
      flags[ccx_pkg::FL_C] != $past(flags[ccx_pkg::FL_C]))
    else $error("carry toggle did not invert carry");

  a_ccf_other_flags: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_CARRY_TOGGLE) |=> flags[6:2] == $past(flags[6:2]))
    else $error("carry toggle changed another flag");

  a_zfill_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_ZERO_FILL) |=> rf[$past(eff_dst)] == 8'h00)
    else $error("zero fill left nonzero byte");

  a_zfill_flags: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_ZERO_FILL) |=> $stable(flags))
    else $error("zero fill changed flags");

  a_ind_ptr_keep: assert property (@(posedge pclk)
    disable iff (!presetn)
    wb && indirect && eff_dst != dst_addr |=>
      rf[dst_addr] == $past(rf[dst_addr]))
    else $error("indirect operation changed the pointer");

  a_inv_result: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_INVERT) |=> rf[$past(eff_dst)] == ~$past(dst_val))
    else $error("invert result wrong");

  a_inv_ind_target: assert property (@(posedge pclk)
    disable iff (!presetn)
    (ce && state == ST_ADDR && indirect) |=> eff_dst == $past(rf[dst_addr]))
    else $error("indirect target not taken from pointer");

  a_inv_flags: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_INVERT) |=>
      flags[ccx_pkg::FL_Z] == ($past(dst_val) == 8'hFF) &&
      flags[ccx_pkg::FL_S] == ~$past(dst_val[7]) &&
      !flags[ccx_pkg::FL_V] &&
      flags[ccx_pkg::FL_C] == $past(flags[ccx_pkg::FL_C]) &&
      flags[3:2] == $past(flags[3:2]))
    else $error("invert flags wrong");

  a_sub_no_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_FLAG_SUB) |=>
      rf[eff_dst] == $past(rf[eff_dst]) &&
      rf[src_addr] == $past(rf[src_addr]))
    else $error("flag-only subtract wrote an operand");

  a_sub_carry: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_FLAG_SUB) |=>
      flags[ccx_pkg::FL_C] == ($past(src_val) > $past(dst_val)))
    else $error("subtract carry wrong");

  a_sub_zero_sign: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_FLAG_SUB) |=>
      flags[ccx_pkg::FL_Z] == ($past(src_val) == $past(dst_val)) &&
      flags[ccx_pkg::FL_S] == 8'($past(dst_val) - $past(src_val)) >> 7 &&
      flags[3:2] == $past(flags[3:2]))
    else $error("subtract zero or sign wrong");

  a_sub_overflow: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wb(ccx_pkg::OP_FLAG_SUB) |=>
      flags[ccx_pkg::FL_V] ==
        (($signed($past(dst_val)) - $signed($past(src_val)) > 127) ||
         ($signed($past(dst_val)) - $signed($past(src_val)) < -128)))
    else $error("subtract overflow wrong");

  a_run_shape: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    (start && ce) |=> s_run)
    else $error("busy window has wrong shape");

endmodule

// ### ccx_pkg.sv
// Shared constants and types for the carry, clear, complement and compare unit
package ccx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CMD     = 8'h00;
  localparam logic [7:0] A_OPER    = 8'h04;
  localparam logic [7:0] A_FLAGS   = 8'h08;
  localparam logic [7:0] A_STATUS  = 8'h0C;
  localparam logic [7:0] A_RF_ADDR = 8'h10;
  localparam logic [7:0] A_RF_DATA = 8'h14;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_CARRY_TOGGLE = 8'hEF;
  localparam logic [7:0] OPC_ZERO_FILL    = 8'hB0;
  localparam logic [7:0] OPC_ZERO_FILL_IR = 8'hB1;
  localparam logic [7:0] OPC_INVERT       = 8'h60;
  localparam logic [7:0] OPC_INVERT_IR    = 8'h61;
  localparam logic [7:0] OPC_FLAG_SUB     = 8'hA2;

  // ----------------------------------------------------------------
  // Flag bit positions and field layout
  // ----------------------------------------------------------------
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;
  localparam int FL_D = 3;
  localparam int FL_H = 2;
  localparam logic [7:0] FLAGS_MASK  = 8'hFC;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam int OPER_DST_LSB = 0;
  localparam int OPER_SRC_LSB = 8;
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_ILLEGAL = 2;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int OP_CYCLES = 4;
  localparam int RF_DEPTH  = 256;

  typedef enum logic [2:0] {
    OP_NONE, OP_CARRY_TOGGLE, OP_ZERO_FILL, OP_INVERT, OP_FLAG_SUB
  } ccx_op_t;

endpackage

// ### ccx_alu.sv
// Result and flag computation for the four operations
`timescale 1ns/1ps
module ccx_alu (
  input  wire ccx_pkg::ccx_op_t op,
  input  wire logic [7:0]       dst,
  input  wire logic [7:0]       src,
  input  wire logic [7:0]       flags_in,
  output logic      [7:0]       result,
  output logic                  wr_en,
  output logic      [7:0]       flags_out
);

  logic [8:0] diff;

  assign diff = {1'b0, dst} - {1'b0, src};

  always_comb begin
    result    = 8'h00;
    wr_en     = 1'b0;
    flags_out = flags_in;
    case (op)
      ccx_pkg::OP_CARRY_TOGGLE: begin
        flags_out[ccx_pkg::FL_C] = ~flags_in[ccx_pkg::FL_C];
      end
      ccx_pkg::OP_ZERO_FILL: begin
        result = 8'h00;
        wr_en  = 1'b1;
      end
      ccx_pkg::OP_INVERT: begin
        result                   = ~dst;
        wr_en                    = 1'b1;
        flags_out[ccx_pkg::FL_Z] = (~dst == 8'h00);
        flags_out[ccx_pkg::FL_S] = ~dst[7];
        flags_out[ccx_pkg::FL_V] = 1'b0;
      end
      ccx_pkg::OP_FLAG_SUB: begin
        // Difference is never written back, only flags
        flags_out[ccx_pkg::FL_C] = diff[8];
        flags_out[ccx_pkg::FL_Z] = (diff[7:0] == 8'h00);
        flags_out[ccx_pkg::FL_S] = diff[7];
        flags_out[ccx_pkg::FL_V] = (dst[7] ^ src[7]) &
                                   (dst[7] ^ diff[7]);
      end
      default: begin
        flags_out = flags_in;
      end
    endcase
  end

endmodule

// ### ccx_apb_dec.sv
// APB address decode for the unit's register map
`timescale 1ns/1ps
module ccx_apb_dec (
  input  wire logic [7:0] paddr,
  output logic            sel_cmd,
  output logic            sel_oper,
  output logic            sel_flags,
  output logic            sel_status,
  output logic            sel_rf_addr,
  output logic            sel_rf_data,
  output logic            hit
);

  assign sel_cmd     = (paddr == ccx_pkg::A_CMD);
  assign sel_oper    = (paddr == ccx_pkg::A_OPER);
  assign sel_flags   = (paddr == ccx_pkg::A_FLAGS);
  assign sel_status  = (paddr == ccx_pkg::A_STATUS);
  assign sel_rf_addr = (paddr == ccx_pkg::A_RF_ADDR);
  assign sel_rf_data = (paddr == ccx_pkg::A_RF_DATA);
  assign hit = sel_cmd | sel_oper | sel_flags | sel_status |
               sel_rf_addr | sel_rf_data;

endmodule

// ### ccx_core_tb.sv
// Self-checking testbench for the carry, clear, complement and compare unit
`timescale 1ns/1ps
module ccx_core_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          failures;
  int          checked;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  fb;
  logic [31:0] exp_fl;
  logic [7:0]  cmp_d [0:4] = '{8'h02, 8'h05, 8'h80, 8'h7F, 8'h03};
  logic [7:0]  cmp_s [0:4] = '{8'h03, 8'h05, 8'h01, 8'hFF, 8'h02};

  ccx_core dut (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request holds until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        failures++;
        close_out();
      end
      @(posedge pclk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic rf_set(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, ccx_pkg::A_RF_ADDR, {24'h0, a});
    apb(1'b1, ccx_pkg::A_RF_DATA, {24'h0, v});
  endtask

  task automatic rf_chk(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, ccx_pkg::A_RF_ADDR, {24'h0, a});
    rdchk(ccx_pkg::A_RF_DATA, {24'h0, v});
  endtask

  task automatic oper(input logic [7:0] dst, input logic [7:0] src);
    apb(1'b1, ccx_pkg::A_OPER, {16'h0, src, dst});
  endtask

  task automatic set_flags(input logic [7:0] f);
    apb(1'b1, ccx_pkg::A_FLAGS, {24'h0, f});
  endtask

  // Polls status rather than counting cycles, then clears done
  task automatic wait_done();
    int n;
    n = 0;
    apb(1'b0, ccx_pkg::A_STATUS, 32'h0);
    while (rd[ccx_pkg::ST_BUSY] !== 1'b0) begin
      n++;
      if (n > 20) begin
        failures++;
        close_out();
      end
      apb(1'b0, ccx_pkg::A_STATUS, 32'h0);
    end
    chk(rd & 32'h7, 32'h2);
    apb(1'b1, ccx_pkg::A_STATUS, 32'h6);
  endtask

  task automatic run_op(input logic [7:0] opc);
    apb(1'b1, ccx_pkg::A_CMD, {24'h0, opc});
    wait_done();
  endtask

  function automatic logic [31:0] cmp_flags(input logic [7:0] d,
                                            input logic [7:0] s,
                                            input logic [7:0] f);
    logic [7:0] diff;
    logic [7:0] e;
    diff = d - s;
    e = f & ccx_pkg::FLAGS_MASK;
    e[ccx_pkg::FL_C] = (s > d);
    e[ccx_pkg::FL_Z] = (diff == 8'h00);
    e[ccx_pkg::FL_S] = diff[7];
    e[ccx_pkg::FL_V] = (d[7] != s[7]) && (diff[7] != d[7]);
    return {24'h0, e};
  endfunction

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn  = 1'b0;
    ce       = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    failures = 0;
    checked  = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ccx_pkg::A_FLAGS, 32'h0);
    rdchk(ccx_pkg::A_STATUS, 32'h0);
    $display("test reset values done");
    // Both carry directions, with every other flag set
    set_flags(8'h7C);
    run_op(ccx_pkg::OPC_CARRY_TOGGLE);
    rdchk(ccx_pkg::A_FLAGS, 32'hFC);
    run_op(ccx_pkg::OPC_CARRY_TOGGLE);
    rdchk(ccx_pkg::A_FLAGS, 32'h7C);
    $display("test carry toggle done");
    rf_set(8'h20, 8'h4F);
    rf_set(8'h21, 8'h33);
    set_flags(8'hA8);
    oper(8'h20, 8'h21);
    run_op(ccx_pkg::OPC_ZERO_FILL);
    rf_chk(8'h20, 8'h00);
    rf_chk(8'h21, 8'h33);
    rdchk(ccx_pkg::A_FLAGS, 32'hA8);
    rf_set(8'h01, 8'h02);
    rf_set(8'h02, 8'h5E);
    set_flags(8'h54);
    oper(8'h01, 8'h00);
    run_op(ccx_pkg::OPC_ZERO_FILL_IR);
    rf_chk(8'h02, 8'h00);
    rf_chk(8'h01, 8'h02);
    rdchk(ccx_pkg::A_FLAGS, 32'h54);
    $display("test zero fill done");
    rf_set(8'h30, 8'h07);
    set_flags(8'h9C);
    oper(8'h30, 8'h00);
    run_op(ccx_pkg::OPC_INVERT);
    rf_chk(8'h30, 8'hF8);
    rdchk(ccx_pkg::A_FLAGS, 32'hAC);
    rf_set(8'h30, 8'hFF);
    set_flags(8'h10);
    run_op(ccx_pkg::OPC_INVERT);
    rf_chk(8'h30, 8'h00);
    rdchk(ccx_pkg::A_FLAGS, 32'h40);
    rf_set(8'h07, 8'hF1);
    rf_set(8'h31, 8'h07);
    oper(8'h31, 8'h00);
    run_op(ccx_pkg::OPC_INVERT_IR);
    rf_chk(8'h07, 8'h0E);
    rf_chk(8'h31, 8'h07);
    $display("test invert done");
    // Borrow, equal, signed overflow both ways, plain positive
    for (int i = 0; i < 5; i++) begin
      fb = i[0] ? 8'hF0 : 8'h0C;
      rf_set(8'h40, cmp_d[i]);
      rf_set(8'h41, cmp_s[i]);
      set_flags(fb);
      oper(8'h40, 8'h41);
      run_op(ccx_pkg::OPC_FLAG_SUB);
      exp_fl = cmp_flags(cmp_d[i], cmp_s[i], fb);
      rdchk(ccx_pkg::A_FLAGS, exp_fl);
      rf_chk(8'h40, cmp_d[i]);
      rf_chk(8'h41, cmp_s[i]);
    end
    $display("test flag-only subtract done");
    // Unmapped place answers with an error and changes nothing
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h18, 32'hFF);
    chk({31'h0, err}, 32'h1);
    rdchk(ccx_pkg::A_FLAGS, cmp_flags(8'h03, 8'h02, 8'h0C));
    $display("test unmapped access done");
    // Frozen run: a flags write after the freeze still meets a busy unit
    set_flags(8'h20);
    apb(1'b1, ccx_pkg::A_CMD, {24'h0, ccx_pkg::OPC_CARRY_TOGGLE});
    ce <= 1'b0;
    repeat (8) @(posedge pclk);
    ce <= 1'b1;
    set_flags(8'h00);
    wait_done();
    rdchk(ccx_pkg::A_FLAGS, 32'hA0);
    $display("test clock enable done");
    // Undefined opcode only raises the illegal bit
    apb(1'b1, ccx_pkg::A_CMD, 32'h0000_00FF);
    rdchk(ccx_pkg::A_STATUS, 32'h4);
    apb(1'b1, ccx_pkg::A_STATUS, 32'h6);
    rdchk(ccx_pkg::A_STATUS, 32'h0);
    rdchk(ccx_pkg::A_FLAGS, 32'hA0);
    $display("test illegal opcode done");
    close_out();
  end

  // ----------------------------------------------------------------
  // Watchdog: the tests need well under a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    #40000;
    failures++;
    close_out();
  end
endmodule
